// ===== verilog/ivs_regs.svh
`ifndef IVS_REGS_SVH
`define IVS_REGS_SVH

// register byte offsets on apb
`define IVS_OFF_SENSE 8'h00
`define IVS_OFF_STATUS 8'h04
`define IVS_OFF_CLEAR 8'h08
`define IVS_OFF_ENABLE 8'h0c
`define IVS_OFF_PEND 8'h10

// reset values
`define IVS_SENSE_RST 8'h00
`define IVS_STS_RST 3'h0
`define IVS_WORD_ZERO 32'h0000_0000

// sense field encodings
`define IVS_SNS_FALL_LOW 2'h0
`define IVS_SNS_RISE 2'h1
`define IVS_SNS_FALL 2'h2
`define IVS_SNS_BOTH 2'h3
`define IVS_FLD_W 2

// status, clear and enable bit positions
`define IVS_STS_REFUSE 0
`define IVS_STS_WAKE 1
`define IVS_STS_EXT 2

// pend register layout
`define IVS_PEND_IDX_LSB 16
`define IVS_PEND_VALID 24
`define IVS_PEND_WAKE 25

// vector slots
`define IVS_NSLOT 14
`define IVS_SLOT_EXT0 1
`define IVS_SLOT_CMP 8
`define IVS_SLOT_OVF 9
`define IVS_SLOT_CAP 10
`define IVS_SLOT_TB 11
`define IVS_SLOT_SPI 12
`define IVS_USED_MASK 14'h1f1e
`define IVS_WAKE_MASK 14'h1a1e
`define IVS_IDX_TRAP 4'he
`define IVS_IDX_RESET 4'hf
`define IVS_VEC_RESET 16'hfffe
`define IVS_VEC_TRAP 16'hfffc
`define IVS_VEC_SLOT0 16'hfffa

`endif

// ===== verilog/ivs_pkg.sv
package ivs_pkg;

   typedef struct packed {
      logic sy1;
      logic sy2;
      logic prev;
      logic edge_pend;
   } ivs_line_state_t;

   typedef struct packed {
      logic [7:0] sense;
      logic [4:0] per_pend;
      logic trap_pend;
      logic rst_pend;
      logic [2:0] sts;
      logic [2:0] ien;
      logic [31:0] prdata;
      logic pslverr;
      logic vec_valid;
      logic [3:0] vec_idx;
      logic [15:0] vec_addr;
      logic wake;
   } ivs_state_t;

endpackage

// ===== verilog/ivs_line_sense.sv
`timescale 1ns/1ns
`include "ivs_regs.svh"

module ivs_line_sense (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic line_pin,
   input wire logic [1:0] sense,
   input wire logic ack_clr,
   output logic req,
   output logic trig
);

   ivs_pkg::ivs_line_state_t s_r;
   ivs_pkg::ivs_line_state_t s_nxt;
   logic rise;
   logic fall;
   logic hit;

   always_comb begin
      s_nxt = s_r;
      s_nxt.sy1 = line_pin;
      s_nxt.sy2 = s_r.sy1;
      s_nxt.prev = s_r.sy2;
      rise = s_r.sy2 & ~s_r.prev;
      fall = ~s_r.sy2 & s_r.prev;
      case (sense) // [R6]
         `IVS_SNS_FALL_LOW: hit = fall;
         `IVS_SNS_RISE: hit = rise;
         `IVS_SNS_FALL: hit = fall;
         default: hit = rise | fall;
      endcase
      // edge latch, a new edge beats the service clear
      s_nxt.edge_pend = hit | (s_r.edge_pend & ~ack_clr);
      // level part of mode 00 holds while the pin stays low
      req = s_r.edge_pend | ((sense == `IVS_SNS_FALL_LOW) & ~s_r.sy2); // [R6]
      trig = hit;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '{sy1: 1'b1, sy2: 1'b1, prev: 1'b1, edge_pend: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

endmodule

// ===== verilog/ivs_vector_sense.sv
// Behaviour
// [R1] the interval-timer compare request vectors at FFEAh-FFEBh and never wakes the core from halt.
// [R2] the interval-timer overflow request vectors at FFE8h-FFE9h and wakes the core from halt.
// [R3] the light-timer capture request vectors at FFE6h-FFE7h and never wakes the core from halt.
// [R4] the light-timer time-base request vectors at FFE4h-FFE5h and wakes the core from halt.
// [R5] bits 1:0 of the sense register set the trigger of external line 0 on port A bit 0.
// [R6] a sense field means 00 falling edge plus low level, 01 rising, 10 falling, 11 both edges.
// [R7] sense writes take effect only while the global mask bit is set, and software sets it first.
// [R8] the sense register clears to zero at reset, so every line starts in falling-plus-low mode.
// [R9] the upper fields, from the top pair down, drive lines 3, 2 and 1 on B0, B3 and A7.
// [R10] reset uses FFFEh first, trap FFFCh, lines 0-3 FFF8h down to FFF2h, serial FFE2h last.
// [R11] among several enabled pending requests the lowest slot index goes first after reset and trap.
// [R12] a maskable request is presented only while the global mask bit is clear.
// [R13] a peripheral request stays latched while its enable is clear or the mask bit is set.
// [R14] the peripheral clear sequence also drops its internal request latch.
// [R15] requests from the external lines wake the processor from halt.
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "ivs_regs.svh"

module ivs_vector_sense (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_line_0,
   input wire logic ext_line_1,
   input wire logic ext_line_2,
   input wire logic ext_line_3,
   input wire logic cpu_imask,
   input wire logic trap_req,
   input wire logic cpu_ack,
   input wire logic [4:0] periph_req,
   input wire logic [4:0] periph_en,
   input wire logic [4:0] periph_clr,
   output logic irq_valid,
   output logic [3:0] vector_index,
   output logic [15:0] vector_addr,
   output logic halt_wake,
   output logic irq_out
);

   ivs_pkg::ivs_state_t st_r;
   ivs_pkg::ivs_state_t st_nxt;

   logic [3:0] ext_pins;
   logic [3:0] ext_req;
   logic [3:0] ext_trig;
   logic [3:0] ext_ack;
   logic [13:0] slot_req;
   logic [13:0] slot_en;
   logic [13:0] cand;
   logic [4:0] pick;
   logic wr_acc;
   logic rd_setup;
   logic ack_slot;

   // lowest set slot, bit 4 marks found
   function automatic logic [4:0] lowest_slot(input logic [13:0] v);
      logic [4:0] r;
      r = 5'h00;
      for (int i = `IVS_NSLOT - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, 4'(i)};
         end
      end
      return r;
   endfunction

   // vector address of a slot, reset or trap
   function automatic logic [15:0] vec_of(input logic [3:0] idx);
      logic [15:0] a;
      if (idx == `IVS_IDX_RESET) begin
         a = `IVS_VEC_RESET;
      end else if (idx == `IVS_IDX_TRAP) begin
         a = `IVS_VEC_TRAP;
      end else begin
         a = `IVS_VEC_SLOT0 - {11'h000, idx, 1'b0};
      end
      return a;
   endfunction

   function automatic logic [31:0] word_of(input logic [7:0] b);
      return {24'h00_0000, b};
   endfunction

   assign ext_pins = {ext_line_3, ext_line_2, ext_line_1, ext_line_0};

   // field 0 on A0, fields 1..3 on A7, B3, B0
   for (genvar g = 0; g < 4; g++) begin : g_line
      ivs_line_sense u_line (
         .pclk(pclk),
         .presetn(presetn),
         .line_pin(ext_pins[g]),
         .sense(st_r.sense[g*`IVS_FLD_W +: `IVS_FLD_W]), // [R5] [R9]
         .ack_clr(ext_ack[g]),
         .req(ext_req[g]),
         .trig(ext_trig[g])
      );
   end

   assign pready = 1'b1;
   assign prdata = st_r.prdata;
   assign pslverr = st_r.pslverr;
   assign irq_valid = st_r.vec_valid;
   assign vector_index = st_r.vec_idx;
   assign vector_addr = st_r.vec_addr;
   assign halt_wake = st_r.wake;
   assign irq_out = |(st_r.sts & st_r.ien);

   always_comb begin
      st_nxt = st_r;
      wr_acc = psel & penable & pwrite;
      rd_setup = psel & ~penable;
      ack_slot = cpu_ack & st_r.vec_valid & (st_r.vec_idx < `IVS_IDX_TRAP);
      ext_ack = 4'h0;
      for (int i = 0; i < 4; i++) begin
         ext_ack[i] = ack_slot & (st_r.vec_idx == 4'(`IVS_SLOT_EXT0 + i));
      end

      // request map over the vector slots
      slot_req = 14'h0000;
      slot_req[`IVS_SLOT_EXT0 +: 4] = ext_req;
      slot_req[`IVS_SLOT_CMP +: 5] = st_r.per_pend;
      slot_en = `IVS_USED_MASK; // [R10]
      slot_en[`IVS_SLOT_CMP +: 5] = periph_en;
      cand = slot_req & slot_en & {`IVS_NSLOT{~cpu_imask}}; // [R12] [R13]
      pick = lowest_slot(cand); // [R11]

      // peripheral latches: new request beats the clear
      st_nxt.per_pend = periph_req | (st_r.per_pend & ~periph_clr); // [R13] [R14]

      // trap and reset service
      st_nxt.trap_pend = trap_req | (st_r.trap_pend & ~(cpu_ack & st_r.vec_idx == `IVS_IDX_TRAP));
      if (cpu_ack & st_r.vec_idx == `IVS_IDX_RESET) begin
         st_nxt.rst_pend = 1'b0;
      end

      // presented vector, reset then trap then lowest slot
      if (st_nxt.rst_pend) begin
         st_nxt.vec_valid = 1'b1;
         st_nxt.vec_idx = `IVS_IDX_RESET; // [R10]
      end else if (st_nxt.trap_pend) begin
         st_nxt.vec_valid = 1'b1;
         st_nxt.vec_idx = `IVS_IDX_TRAP; // [R10]
      end else begin
         st_nxt.vec_valid = pick[4] & ~ack_slot;
         st_nxt.vec_idx = pick[3:0];
      end
      st_nxt.vec_addr = vec_of(st_nxt.vec_idx); // [R1] [R2] [R3] [R4] [R10]

      // halt wake: external lines, overflow, time base, serial only
      st_nxt.wake = |(slot_req & slot_en & `IVS_WAKE_MASK); // [R1] [R2] [R3] [R4] [R15]

      // sticky events, set wins over clear
      if (wr_acc & paddr == `IVS_OFF_CLEAR) begin
         st_nxt.sts = st_r.sts & ~pwdata[2:0];
      end
      if (wr_acc & paddr == `IVS_OFF_SENSE & ~cpu_imask) begin
         st_nxt.sts[`IVS_STS_REFUSE] = 1'b1;
      end
      if (st_nxt.wake & ~st_r.wake) begin
         st_nxt.sts[`IVS_STS_WAKE] = 1'b1;
      end
      if (|ext_trig) begin
         st_nxt.sts[`IVS_STS_EXT] = 1'b1;
      end

      // register writes
      if (wr_acc & paddr == `IVS_OFF_SENSE & cpu_imask) begin
         st_nxt.sense = pwdata[7:0]; // [R7]
      end
      if (wr_acc & paddr == `IVS_OFF_ENABLE) begin
         st_nxt.ien = pwdata[2:0];
      end

      // read data and error captured in the setup cycle
      if (rd_setup) begin
         st_nxt.pslverr = 1'b0;
         case (paddr)
            `IVS_OFF_SENSE: st_nxt.prdata = word_of(st_r.sense);
            `IVS_OFF_STATUS: st_nxt.prdata = word_of({5'h00, st_r.sts});
            `IVS_OFF_CLEAR: st_nxt.prdata = `IVS_WORD_ZERO;
            `IVS_OFF_ENABLE: st_nxt.prdata = word_of({5'h00, st_r.ien});
            `IVS_OFF_PEND: begin
               st_nxt.prdata = `IVS_WORD_ZERO;
               st_nxt.prdata[13:0] = slot_req;
               st_nxt.prdata[`IVS_PEND_IDX_LSB +: 4] = st_r.vec_idx;
               st_nxt.prdata[`IVS_PEND_VALID] = st_r.vec_valid;
               st_nxt.prdata[`IVS_PEND_WAKE] = st_r.wake;
            end
            default: begin
               st_nxt.prdata = `IVS_WORD_ZERO;
               st_nxt.pslverr = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r.sense <= `IVS_SENSE_RST; // [R8]
         st_r.per_pend <= 5'h00;
         st_r.trap_pend <= 1'b0;
         st_r.rst_pend <= 1'b1;
         st_r.sts <= `IVS_STS_RST;
         st_r.ien <= `IVS_STS_RST;
         st_r.prdata <= `IVS_WORD_ZERO;
         st_r.pslverr <= 1'b0;
         st_r.vec_valid <= 1'b1;
         st_r.vec_idx <= `IVS_IDX_RESET;
         st_r.vec_addr <= `IVS_VEC_RESET;
         st_r.wake <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_sense_refused: assert property ( // [R7]
      (wr_acc && paddr == `IVS_OFF_SENSE && !cpu_imask) |=> $stable(st_r.sense))
      else $error("sense changed while mask bit clear");

   a_sense_taken: assert property ( // [R7]
      (wr_acc && paddr == `IVS_OFF_SENSE && cpu_imask) |=> st_r.sense == $past(pwdata[7:0]))
      else $error("sense write lost while mask bit set");

   a_vec_masked: assert property ( // [R12]
      (st_r.vec_valid && st_r.vec_idx < `IVS_IDX_TRAP) |-> !$past(cpu_imask))
      else $error("maskable vector shown while masked");

   a_vec_addr_map: assert property ( // [R10]
      (st_r.vec_valid && st_r.vec_idx < `IVS_IDX_TRAP)
         |-> st_r.vec_addr == 16'hfffa - {11'h000, st_r.vec_idx, 1'b0})
      else $error("slot vector address wrong");

   a_ovf_vector: assert property ( // [R2]
      (st_r.vec_valid && st_r.vec_idx == 4'h9) |-> st_r.vec_addr == 16'hffe8)
      else $error("overflow vector wrong");

   a_cmp_nowake: assert property ( // [R1]
      ($past(slot_req & slot_en) == 14'h0100) |-> !st_r.wake)
      else $error("compare request woke from halt");

   a_ext_wake: assert property ( // [R15]
      (|(ext_req) && !$past(|ext_req)) |-> ##1 st_r.wake)
      else $error("external line did not wake");

   a_prio_lowest: assert property ( // [R11]
      (st_r.vec_valid && st_r.vec_idx < `IVS_IDX_TRAP && !$past(ack_slot))
         |-> ($past(cand) & ((14'h0001 << st_r.vec_idx) - 14'h0001)) == 14'h0000)
      else $error("lower slot was pending");

   a_latch_hold: assert property ( // [R13]
      1'b1 |=> (($past(st_r.per_pend) & ~$past(periph_clr)) & ~st_r.per_pend) == 5'h00)
      else $error("peripheral latch dropped without clear");

   a_clr_drop: assert property ( // [R14]
      (|(periph_clr & ~periph_req)) |=> (st_r.per_pend & $past(periph_clr & ~periph_req)) == 5'h00)
      else $error("clear sequence left latch set");

   a_reset_first: assert property ( // [R10]
      (st_r.rst_pend && !cpu_ack) |-> (st_r.vec_idx == `IVS_IDX_RESET && st_r.vec_addr == 16'hfffe) [*2])
      else $error("reset vector not presented first");

   a_cap_nowake: assert property ( // [R3]
      ($past(slot_req & slot_en) == 14'h0400) |-> !st_r.wake)
      else $error("capture request woke from halt");

   a_tb_wake: assert property ( // [R4]
      $past(slot_req[`IVS_SLOT_TB] & slot_en[`IVS_SLOT_TB]) |-> st_r.wake)
      else $error("time base request did not wake");

   a_ovf_wake: assert property ( // [R2]
      $past(slot_req[`IVS_SLOT_OVF] & slot_en[`IVS_SLOT_OVF]) |-> st_r.wake)
      else $error("overflow request did not wake");

   a_cmp_vector: assert property ( // [R1]
      (st_r.vec_valid && st_r.vec_idx == 4'(`IVS_SLOT_CMP)) |-> st_r.vec_addr == 16'hffea)
      else $error("compare vector wrong");

   a_cap_vector: assert property ( // [R3]
      (st_r.vec_valid && st_r.vec_idx == 4'(`IVS_SLOT_CAP)) |-> st_r.vec_addr == 16'hffe6)
      else $error("capture vector wrong");

   a_tb_vector: assert property ( // [R4]
      (st_r.vec_valid && st_r.vec_idx == 4'(`IVS_SLOT_TB)) |-> st_r.vec_addr == 16'hffe4)
      else $error("time base vector wrong");

   a_spi_vector: assert property ( // [R10]
      (st_r.vec_valid && st_r.vec_idx == 4'(`IVS_SLOT_SPI)) |-> st_r.vec_addr == 16'hffe2)
      else $error("serial vector wrong");

   a_trap_vector: assert property ( // [R10]
      (st_r.vec_valid && st_r.vec_idx == `IVS_IDX_TRAP) |-> st_r.vec_addr == 16'hfffc)
      else $error("trap vector wrong");

   a_unused_slot: assert property ( // [R10]
      st_r.vec_valid |-> !(st_r.vec_idx inside {4'h0, 4'h5, 4'h6, 4'h7, 4'hd}))
      else $error("unused slot presented");

   a_line0_field: assert property ( // [R5]
      1'b1 |-> g_line[0].u_line.sense == st_r.sense[1:0])
      else $error("line 0 sense field misrouted");

   a_line3_field: assert property ( // [R9]
      1'b1 |-> g_line[3].u_line.sense == st_r.sense[7:6])
      else $error("line 3 sense field misrouted");

   a_ext_hit_sts: assert property ( // [R6]
      $past(|ext_trig) |-> st_r.sts[`IVS_STS_EXT])
      else $error("external trigger not recorded");

endmodule

// ===== dv/ivs_cpu_model.sv
`timescale 1ns/1ns

module ivs_cpu_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic go,
   input wire logic irq_valid,
   output logic cpu_ack
);
   logic [1:0] cool_r;
   logic take;

   // one-cycle ack, then a pause so a stale vector is never taken twice
   assign take = go && irq_valid && cool_r == 2'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cool_r <= 2'h0;
         cpu_ack <= 1'b0;
      end else begin
         cpu_ack <= take;
         cool_r <= take ? 2'h3 : cool_r - {1'b0, cool_r != 2'h0};
      end
   end
endmodule

// ===== dv/testbench.sv
`timescale 1ns/1ns

module testbench;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic cpu_imask = 1'b1, trap_req = 1'b0, go = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] ext = 4'hf;
   logic [4:0] periph_req = 5'h00, periph_en = 5'h00, periph_clr = 5'h00;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er, cpu_ack, irq_valid, halt_wake, irq_out;
   logic [3:0] vector_index;
   logic [15:0] vector_addr;
   logic [7:0] s;
   localparam logic [4:0] wake_src = 5'h1a;
   int n_errors = 0;
   int n_checks = 0;

   always #2 pclk = ~pclk;

   ivs_vector_sense u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .ext_line_0(ext[0]), .ext_line_1(ext[1]), .ext_line_2(ext[2]), .ext_line_3(ext[3]),
      .cpu_imask, .trap_req, .cpu_ack, .periph_req, .periph_en, .periph_clr, .irq_valid, .vector_index,
      .vector_addr, .halt_wake, .irq_out);
   ivs_cpu_model u_cpu (.pclk, .presetn, .go, .irq_valid, .cpu_ack);

   task results();
      $display("errors %0d checks %0d", n_errors, n_checks);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task chk(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         n_errors++;
         results();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task ack();
      go <= 1'b1;
      cyc(1);
      go <= 1'b0;
      cyc(5);
   endtask

   initial begin
      int k;
      int m;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      cyc(1);
      chk({irq_valid, vector_index, vector_addr, halt_wake, irq_out}, {5'h1f, 16'hfffe, 2'h0});
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      go <= 1'b1;
      cyc(6);
      go <= 1'b0;
      cyc(3);
      chk(irq_valid, 1'b0);
      cpu_imask <= 1'b0;
      apb(1'b1, 8'h00, 32'h0000_00e4);
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      apb(1'b0, 8'h04, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
      chk(irq_out, 1'b0);
      apb(1'b1, 8'h0c, 32'h0000_0001);
      cyc(1);
      chk(irq_out, 1'b1);
      apb(1'b1, 8'h08, 32'h0000_0001);
      cyc(1);
      chk(irq_out, 1'b0);
      apb(1'b0, 8'h20, 32'h0000_0000);
      chk({er, rd}, {1'b1, 32'h0000_0000});
      cpu_imask <= 1'b1;
      apb(1'b1, 8'h00, 32'h0000_00e4);
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk(rd, 32'h0000_00e4);
      // one field per pass, the others set to a differing mode
      for (k = 0; k < 4; k++) begin
         for (m = 0; m < 4; m++) begin
            s = (m == 1) ? 8'haa : 8'h55;
            s[2 * k +: 2] = m[1:0];
            cpu_imask <= 1'b1;
            apb(1'b1, 8'h00, {24'h00_0000, s});
            cpu_imask <= 1'b0;
            ext[k] <= 1'b0;
            cyc(6);
            chk({irq_valid, halt_wake}, {2{m != 1}});
            if (m != 1) chk({vector_index, vector_addr}, {4'(k + 1), 16'hfff8 - 16'(2 * k)});
            go <= 1'b1;
            cyc(8);
            go <= 1'b0;
            cyc(3);
            chk(irq_valid, m == 0);
            ext[k] <= 1'b1;
            cyc(6);
            chk(irq_valid, m == 1 || m == 3);
            go <= 1'b1;
            cyc(8);
            go <= 1'b0;
            cyc(3);
            chk(irq_valid, 1'b0);
         end
      end
      apb(1'b0, 8'h04, 32'h0000_0000);
      chk(rd, 32'h0000_0006);
      apb(1'b1, 8'h08, 32'h0000_0006);
      apb(1'b0, 8'h04, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      for (k = 0; k < 5; k++) begin
         cpu_imask <= 1'b1;
         periph_req <= 5'h01 << k;
         periph_en <= 5'h01 << k;
         cyc(4);
         chk(irq_valid, 1'b0);
         cpu_imask <= 1'b0;
         cyc(4);
         chk({irq_valid, vector_index}, {1'b1, 4'(8 + k)});
         chk({vector_addr, halt_wake}, {16'hffea - 16'(2 * k), wake_src[k]});
         apb(1'b0, 8'h10, 32'h0000_0000);
         chk(rd, {6'h00, wake_src[k], 1'b1, 4'h0, 4'(8 + k), 2'h0, 1'b0, 5'h01 << k, 8'h00});
         periph_req <= 5'h00;
         periph_clr <= 5'h01 << k;
         cyc(1);
         periph_clr <= 5'h00;
         cyc(4);
         chk(irq_valid, 1'b0);
      end
      cpu_imask <= 1'b1;
      periph_req <= 5'h1f;
      periph_en <= 5'h1f;
      ext[3] <= 1'b0;
      trap_req <= 1'b1;
      cyc(1);
      trap_req <= 1'b0;
      cyc(5);
      chk({irq_valid, vector_index, vector_addr}, {5'h1e, 16'hfffc});
      cpu_imask <= 1'b0;
      ack();
      chk(vector_index, 4'h4);
      ack();
      chk(vector_index, 4'h8);
      periph_req <= 5'h00;
      periph_en <= 5'h00;
      periph_clr <= 5'h1f;
      cyc(1);
      periph_clr <= 5'h00;
      periph_req <= 5'h02;
      cyc(2);
      periph_req <= 5'h00;
      cyc(2);
      chk(irq_valid, 1'b0);
      periph_en <= 5'h02;
      cyc(4);
      chk({irq_valid, vector_index}, {1'b1, 4'h9});
      periph_en <= 5'h00;
      periph_clr <= 5'h02;
      cyc(1);
      periph_clr <= 5'h00;
      periph_en <= 5'h02;
      cyc(4);
      chk(irq_valid, 1'b0);
      results();
   end
endmodule
